/* verilog/txcps_top.sv */
`timescale 1ns/1ps
// Overview of operation
// RULE_01: Rate select high: bit-rate clock is reference times twenty.
// RULE_02: Rate select low: bit-rate clock is reference times ten.
// RULE_03: Rate high, rx from reference: both rx clock pairs half-rate, follow reference.
// RULE_04: Rate low, rx from reference: both rx clock pairs full-rate, follow reference.
// RULE_05: Configurer must not pair half-rate reference with lane input clocking.
// RULE_06: Host supplies lane clocks frequency-coherent to character clock; phase offset allowed.
// RULE_07: Lane phase keeps adjusting while phase reset low, frozen once high.
// RULE_08: Host holds phase reset low for at least two reference edges.
// RULE_09: Clock select low reference, mid own lane clock, high lane A clock.
// RULE_10: Character clock at reference rate when rate low, twice when high.
// RULE_11: Rate select is static; changes apply only at a new phase-align reset.
module txcps_top
   import txcps_pkg::*;
(
   // Reference clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Lane input clocks
   input wire logic tx_lane_a_input_clock,
   input wire logic tx_lane_b_input_clock,
   input wire logic tx_lane_c_input_clock,
   input wire logic tx_lane_d_input_clock,
   // Static configuration pins
   input wire logic tx_pll_rate_select,
   input wire logic [1:0] tx_input_clock_select,
   input wire logic rx_clock_source_select,
   // Phase align reset pin
   input wire logic tx_phase_align_reset_n,
   // Transmit clocking
   output logic [4:0] tx_bit_rate_mult_q,
   output logic tx_character_clock_out_p,
   output logic tx_character_clock_out_n,
   // Receive interface clocks
   output logic rx_interface_clock_pair_a_p,
   output logic rx_interface_clock_pair_a_n,
   output logic rx_interface_clock_pair_c_p,
   output logic rx_interface_clock_pair_c_n,
   output logic rx_clock_half_rate_q,
   // Lane clock routing and phase status
   output logic [LANES-1:0][1:0] lane_clock_source_q,
   output logic [LANES-1:0][PHASE_W-1:0] lane_phase_q,
   output logic [LANES-1:0] lane_locked_q,
   // Configuration status
   output logic mode_invalid_q,
   output logic align_active_q
);
   // ==========================================================
   // Declarations
   // ==========================================================
   logic [3:0] pins_in;
   logic [3:0] pins_sync;
   logic rate_pin;
   logic [1:0] sel_pin;
   logic align_low;
   logic rx_src_pin;
   logic rx_src_q;
   logic rate_q;
   logic [1:0] sel_q;
   logic [1:0] low_cnt_q;
   logic bypass;
   logic align_run_q;
   logic [LANES-1:0] lane_clk;
   logic [LANES-1:0][PHASE_W-1:0] raw_phase;
   logic [LANES-1:0] raw_locked;
   logic [1:0] ref_cnt_q;
   logic ref_ph_q;
   logic [1:0] char_cnt_q;
   logic [1:0] char_limit;
   logic char_ph_q;
   txcps_state_t state_q;

   assign lane_clk = {tx_lane_d_input_clock, tx_lane_c_input_clock,
                      tx_lane_b_input_clock, tx_lane_a_input_clock};

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   assign pins_in = {rx_clock_source_select, tx_pll_rate_select, tx_input_clock_select};

   txcps_sync2 #(.W(4)) u_pin_sync (
      .clk(mclk),
      .resetn(resetn),
      .d(pins_in),
      .q(pins_sync)
   );

   // Reset pin synchronised apart: its idle level is high
   logic align_n_meta_q;
   logic align_n_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         align_n_meta_q <= 1'b1;
         align_n_q <= 1'b1;
      end else begin
         align_n_meta_q <= tx_phase_align_reset_n;
         align_n_q <= align_n_meta_q;
      end
   end

   assign sel_pin = pins_sync[1:0];
   assign rate_pin = pins_sync[2];
   assign rx_src_pin = pins_sync[3];
   assign align_low = !align_n_q;

   // ==========================================================
   // Initialisation sequence
   // ==========================================================
   // Configuration is captured once after reset release, then only
   // when a fresh phase-align reset has been seen long enough.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         state_q <= TXCPS_ST_INIT;
      end else begin
         case (state_q)
            TXCPS_ST_INIT: begin
               state_q <= TXCPS_ST_RUN;
            end
            TXCPS_ST_RUN: begin
               if (align_low && low_cnt_q >= ALIGN_MIN_LOW_EDGES - 2'h1) begin
                  state_q <= TXCPS_ST_ALIGN; // see RULE_11
               end
            end
            TXCPS_ST_ALIGN: begin
               if (!align_low) begin
                  state_q <= TXCPS_ST_RUN;
               end
            end
            default: begin
               state_q <= TXCPS_ST_INIT;
            end
         endcase
      end
   end

   // Consecutive low samples of the phase reset, saturating
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         low_cnt_q <= 2'h0;
      end else if (!align_low) begin
         low_cnt_q <= 2'h0;
      end else if (low_cnt_q < ALIGN_MIN_LOW_EDGES) begin
         low_cnt_q <= low_cnt_q + 2'h1; // see RULE_08
      end
   end

   // ==========================================================
   // Static configuration capture
   // ==========================================================
   // Mid-frame changes of the pins are ignored on purpose: a live
   // rate change would tear the character clock under the lanes.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rate_q <= RATE_RESET;
         sel_q <= SEL_RESET;
         rx_src_q <= 1'b0;
      end else if (state_q == TXCPS_ST_INIT || state_q == TXCPS_ST_ALIGN) begin
         rate_q <= rate_pin; // see RULE_11
         sel_q <= sel_pin;
         rx_src_q <= rx_src_pin;
      end
   end

   // Illegal pin code three is treated as mid, the self-biased level
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         mode_invalid_q <= 1'b0;
      end else begin
         mode_invalid_q <= rate_q && (sel_q != SEL_LOW); // see RULE_05
      end
   end

   // ==========================================================
   // Transmit PLL multiplier
   // ==========================================================
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tx_bit_rate_mult_q <= MULT_RESET;
      end else if (rate_q) begin
         tx_bit_rate_mult_q <= MULT_HIGH_RATE; // see RULE_01
      end else begin
         tx_bit_rate_mult_q <= MULT_LOW_RATE; // see RULE_02
      end
   end

   // ==========================================================
   // Scaled reference and character clocks
   // ==========================================================
   // Reference is modelled as a toggle every two mclk cycles, so the
   // doubled character clock can still be built from flops.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ref_cnt_q <= 2'h0;
         ref_ph_q <= 1'b0;
      end else if (ref_cnt_q == REF_TOGGLE_CYC - 2'h1) begin
         ref_cnt_q <= 2'h0;
         ref_ph_q <= !ref_ph_q;
      end else begin
         ref_cnt_q <= ref_cnt_q + 2'h1;
      end
   end

   assign char_limit = rate_q ? CHAR_TOGGLE_CYC_HIGH : CHAR_TOGGLE_CYC_LOW;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         char_cnt_q <= 2'h0;
         char_ph_q <= 1'b0;
      end else if (char_cnt_q >= char_limit - 2'h1) begin
         char_cnt_q <= 2'h0;
         char_ph_q <= !char_ph_q; // see RULE_10
      end else begin
         char_cnt_q <= char_cnt_q + 2'h1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         tx_character_clock_out_p <= 1'b0;
         tx_character_clock_out_n <= 1'b1;
      end else begin
         tx_character_clock_out_p <= char_ph_q;
         tx_character_clock_out_n <= !char_ph_q;
      end
   end

   // ==========================================================
   // Receive interface clocks
   // ==========================================================
   // Recovered clocks lie outside this block; pairs idle low when
   // the receive side is not reference clocked.
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rx_interface_clock_pair_a_p <= 1'b0;
         rx_interface_clock_pair_a_n <= 1'b1;
         rx_interface_clock_pair_c_p <= 1'b0;
         rx_interface_clock_pair_c_n <= 1'b1;
         rx_clock_half_rate_q <= 1'b0;
      end else if (!rx_src_q) begin
         rx_interface_clock_pair_a_p <= ref_ph_q; // see RULE_03
         rx_interface_clock_pair_a_n <= !ref_ph_q; // see RULE_04
         rx_interface_clock_pair_c_p <= ref_ph_q; // see RULE_03
         rx_interface_clock_pair_c_n <= !ref_ph_q; // see RULE_04
         rx_clock_half_rate_q <= rate_q; // see RULE_03
      end else begin
         rx_interface_clock_pair_a_p <= 1'b0;
         rx_interface_clock_pair_a_n <= 1'b1;
         rx_interface_clock_pair_c_p <= 1'b0;
         rx_interface_clock_pair_c_n <= 1'b1;
         rx_clock_half_rate_q <= 1'b0;
      end
   end

   // ==========================================================
   // Phase alignment control
   // ==========================================================
   // Buffer is bypassed when reference clocked at full rate
   assign bypass = (sel_q == SEL_LOW) && !rate_q;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         align_run_q <= 1'b0;
         align_active_q <= 1'b0;
      end else begin
         align_run_q <= align_low && !bypass; // see RULE_07
         align_active_q <= align_low && !bypass;
      end
   end

   // ==========================================================
   // Per-lane phase tracking and clock routing
   // ==========================================================
   for (genvar g = 0; g < LANES; g++) begin : g_lane
      txcps_lane_phase u_phase (
         .lane_clk(lane_clk[g]),
         .mclk(mclk),
         .resetn(resetn),
         .align_run(align_run_q),
         .phase_q(raw_phase[g]),
         .locked_q(raw_locked[g])
      );

      always_ff @(posedge mclk or negedge resetn) begin
         if (!resetn) begin
            lane_clock_source_q[g] <= SRC_REFERENCE;
            lane_phase_q[g] <= '0;
            lane_locked_q[g] <= 1'b0;
         end else begin
            case (sel_q)
               SEL_LOW: begin
                  lane_clock_source_q[g] <= SRC_REFERENCE; // see RULE_09
                  lane_phase_q[g] <= '0;
                  lane_locked_q[g] <= !align_run_q;
               end
               SEL_HIGH: begin
                  lane_clock_source_q[g] <= SRC_LANE_A; // see RULE_09
                  lane_phase_q[g] <= raw_phase[LANE_A]; // see RULE_06
                  lane_locked_q[g] <= raw_locked[LANE_A];
               end
               default: begin
                  lane_clock_source_q[g] <= SRC_OWN_LANE; // see RULE_09
                  lane_phase_q[g] <= raw_phase[g]; // see RULE_06
                  lane_locked_q[g] <= raw_locked[g];
               end
            endcase
         end
      end
   end

endmodule : txcps_top

/* common/txcps_pkg.sv */
package txcps_pkg;

   // ==========================================================
   // Lane count and three-level select codes
   // ==========================================================
   localparam int LANES = 4;
   localparam int LANE_A = 0;
   localparam logic [1:0] SEL_LOW = 2'h0;
   localparam logic [1:0] SEL_MID = 2'h1;
   localparam logic [1:0] SEL_HIGH = 2'h2;

   // ==========================================================
   // Clock source codes reported per lane
   // ==========================================================
   localparam logic [1:0] SRC_REFERENCE = 2'h0;
   localparam logic [1:0] SRC_OWN_LANE = 2'h1;
   localparam logic [1:0] SRC_LANE_A = 2'h2;

   // ==========================================================
   // Transmit PLL multipliers
   // ==========================================================
   localparam logic [4:0] MULT_HIGH_RATE = 5'h14;
   localparam logic [4:0] MULT_LOW_RATE = 5'h0a;

   // ==========================================================
   // Phase reset and scaled clock model
   // ==========================================================
   localparam logic [1:0] ALIGN_MIN_LOW_EDGES = 2'h2;
   localparam int PHASE_W = 2;
   localparam logic [1:0] REF_TOGGLE_CYC = 2'h2;
   localparam logic [1:0] CHAR_TOGGLE_CYC_LOW = 2'h2;
   localparam logic [1:0] CHAR_TOGGLE_CYC_HIGH = 2'h1;

   // ==========================================================
   // Reset values
   // ==========================================================
   localparam logic RATE_RESET = 1'b0;
   localparam logic [1:0] SEL_RESET = 2'h0;
   localparam logic [4:0] MULT_RESET = 5'h0a;

   typedef enum logic [1:0] {
      TXCPS_ST_INIT,
      TXCPS_ST_ALIGN,
      TXCPS_ST_RUN
   } txcps_state_t;

endpackage : txcps_pkg

/* verilog/txcps_sync2.sv */
`timescale 1ns/1ps
module txcps_sync2 #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic resetn,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q;

   // ==========================================================
   // Two flops, first one read only by the second
   // ==========================================================
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= '0;
         q <= '0;
      end else begin
         meta_q <= d;
         q <= meta_q;
      end
   end

endmodule : txcps_sync2

/* verilog/txcps_lane_phase.sv */
`timescale 1ns/1ps
module txcps_lane_phase
   import txcps_pkg::*;
(
   // Clocks and reset
   input wire logic lane_clk,
   input wire logic mclk,
   input wire logic resetn,
   // Control, mclk domain
   input wire logic align_run,
   // Status, mclk domain
   output logic [PHASE_W-1:0] phase_q,
   output logic locked_q
);
   logic [1:0] lrst_q;
   logic [PHASE_W-1:0] wr_bin_q;
   logic [PHASE_W-1:0] wr_gray_q;
   logic [PHASE_W-1:0] wr_gray_sync;
   logic [PHASE_W-1:0] wr_bin_sync;
   logic [PHASE_W-1:0] rd_q;
   logic [PHASE_W-1:0] offset;

   // ==========================================================
   // Lane clock domain
   // ==========================================================
   // Reset release is synchronised so the pointer starts cleanly
   always_ff @(posedge lane_clk or negedge resetn) begin
      if (!resetn) begin
         lrst_q <= 2'h0;
      end else begin
         lrst_q <= {lrst_q[0], 1'b1};
      end
   end

   // Gray pointer: one bit changes per edge, safe to cross
   always_ff @(posedge lane_clk or negedge resetn) begin
      if (!resetn) begin
         wr_bin_q <= '0;
         wr_gray_q <= '0;
      end else if (lrst_q[1]) begin
         wr_bin_q <= wr_bin_q + 1'b1;
         wr_gray_q <= (wr_bin_q + 1'b1) ^ ((wr_bin_q + 1'b1) >> 1);
      end
   end

   // ==========================================================
   // Crossing into mclk
   // ==========================================================
   txcps_sync2 #(.W(PHASE_W)) u_ptr_sync (
      .clk(mclk),
      .resetn(resetn),
      .d(wr_gray_q),
      .q(wr_gray_sync)
   );

   always_comb begin
      wr_bin_sync[PHASE_W-1] = wr_gray_sync[PHASE_W-1];
      for (int i = PHASE_W - 2; i >= 0; i--) begin
         wr_bin_sync[i] = wr_bin_sync[i+1] ^ wr_gray_sync[i];
      end
      offset = wr_bin_sync - rd_q;
   end

   // ==========================================================
   // Phase tracking, mclk domain
   // ==========================================================
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         rd_q <= '0;
      end else begin
         rd_q <= rd_q + 1'b1;
      end
   end

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         phase_q <= '0;
         locked_q <= 1'b0;
      end else if (align_run) begin
         phase_q <= offset; // see RULE_07
         locked_q <= 1'b0;
      end else begin
         locked_q <= 1'b1; // see RULE_07
      end
   end

endmodule : txcps_lane_phase

/* dv/txcps_top_asserts.sv */
`timescale 1ns/1ps
// ==========
// Port checker
// ==========
module txcps_top_asserts
   import txcps_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic resetn,
   // Pins
   input wire logic tx_phase_align_reset_n,
   // Clock outputs
   input wire logic [4:0] tx_bit_rate_mult_q,
   input wire logic tx_character_clock_out_p,
   input wire logic tx_character_clock_out_n,
   input wire logic rx_interface_clock_pair_a_p,
   input wire logic rx_interface_clock_pair_a_n,
   input wire logic rx_interface_clock_pair_c_p,
   input wire logic rx_interface_clock_pair_c_n,
   // Status
   input wire logic rx_clock_half_rate_q,
   input wire logic [LANES-1:0][1:0] lane_clock_source_q,
   input wire logic [LANES-1:0][PHASE_W-1:0] lane_phase_q,
   input wire logic [LANES-1:0] lane_locked_q,
   input wire logic mode_invalid_q,
   input wire logic align_active_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!resetn);

   // Cycles since phase reset pin low; reset counts as low for first capture
   logic [3:0] since_low_q;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         since_low_q <= 4'h0;
      end else if (!tx_phase_align_reset_n) begin
         since_low_q <= 4'h0;
      end else if (since_low_q != 4'hf) begin
         since_low_q <= since_low_q + 4'h1;
      end
   end

   // Six cycles of margin: mult and char clock settle from one capture
   property p_char_fast;
      (tx_bit_rate_mult_q == MULT_HIGH_RATE) [*6] |->
         tx_character_clock_out_p != $past(tx_character_clock_out_p);
   endproperty
   a_char_fast: assert property (p_char_fast) else $error("char clock not fast");
   property p_char_slow;
      (tx_bit_rate_mult_q == MULT_LOW_RATE) [*6] |->
         tx_character_clock_out_p != $past(tx_character_clock_out_p, 2);
   endproperty
   a_char_slow: assert property (p_char_slow) else $error("char clock not slow");
   property p_complement;
      tx_character_clock_out_n == !tx_character_clock_out_p &&
         rx_interface_clock_pair_a_n == !rx_interface_clock_pair_a_p &&
         rx_interface_clock_pair_c_n == !rx_interface_clock_pair_c_p;
   endproperty
   a_complement: assert property (p_complement) else $error("pair not complementary");
   property p_rx_match;
      rx_interface_clock_pair_a_p == rx_interface_clock_pair_c_p;
   endproperty
   a_rx_match: assert property (p_rx_match) else $error("rx pairs differ");
   property p_rx_duty;
      rx_interface_clock_pair_a_p [*2] |=> !rx_interface_clock_pair_a_p;
   endproperty
   a_rx_duty: assert property (p_rx_duty) else $error("rx clock high too long");
   property p_cfg_flags;
      (tx_bit_rate_mult_q == MULT_LOW_RATE) [*3] |-> !rx_clock_half_rate_q && !mode_invalid_q;
   endproperty
   a_cfg_flags: assert property (p_cfg_flags) else $error("flag set at low rate");
   property p_lane_source;
      lane_clock_source_q == {LANES{lane_clock_source_q[0]}} && lane_clock_source_q[0] != 2'h3;
   endproperty
   a_lane_source: assert property (p_lane_source) else $error("lane sources disagree");
   // Lane lock status trails the run flag by two flops, by one when lanes are reference clocked
   property p_align_unlocked;
      align_active_q [*3] |-> lane_locked_q == 4'h0;
   endproperty
   a_align_unlocked: assert property (p_align_unlocked) else $error("locked while aligning");
   property p_lock_after;
      $fell(align_active_q) |-> ##[0:3] lane_locked_q == 4'hf;
   endproperty
   a_lock_after: assert property (p_lock_after) else $error("no lock after align");
   // Lane mux may switch at capture even in bypass, so wait out the pin itself
   property p_phase_frozen;
      since_low_q > 4'h5 |-> $stable(lane_phase_q);
   endproperty
   a_phase_frozen: assert property (p_phase_frozen) else $error("phase moved while locked");
   property p_rate_static;
      $changed(tx_bit_rate_mult_q) |-> since_low_q < 4'ha;
   endproperty
   a_rate_static: assert property (p_rate_static) else $error("rate changed without reset");
endmodule : txcps_top_asserts

bind txcps_top txcps_top_asserts u_asserts (
   .mclk, .resetn, .tx_phase_align_reset_n, .tx_bit_rate_mult_q,
   .tx_character_clock_out_p, .tx_character_clock_out_n,
   .rx_interface_clock_pair_a_p, .rx_interface_clock_pair_a_n,
   .rx_interface_clock_pair_c_p, .rx_interface_clock_pair_c_n,
   .rx_clock_half_rate_q, .lane_clock_source_q, .lane_phase_q,
   .lane_locked_q, .mode_invalid_q, .align_active_q
);

/* dv/txcps_host_model.sv */
`timescale 1ns/1ps
// ==========
// Host logic: lane clocks and phase reset
// ==========
module txcps_host_model (
   // Bench control
   input wire logic mclk,
   input wire logic align_go,
   input wire logic [3:0] low_len,
   // Device pins
   output logic [3:0] lane_clk,
   output logic tx_phase_align_reset_n
);
   logic base_clk = 1'b0;
   logic go;
   logic [3:0] low_cnt = 4'h0;

   // One 80 ns source with fixed skews keeps the lanes coherent
   initial begin
      #7;
      forever #40 base_clk = ~base_clk;
   end
   assign lane_clk[0] = base_clk;
   assign #9 lane_clk[1] = base_clk;
   assign #18 lane_clk[2] = base_clk;
   assign #27 lane_clk[3] = base_clk;

   // Length of 1 breaks the two-edge minimum, only when the bench asks
   always @(posedge mclk) begin
      go = align_go;
      #2;
      if (go) begin
         low_cnt = low_len;
      end else if (low_cnt != 4'h0) begin
         low_cnt = low_cnt - 4'h1;
      end
   end
   assign tx_phase_align_reset_n = (low_cnt == 4'h0);
endmodule : txcps_host_model

/* dv/tb_top.sv */
`timescale 1ns/1ps
module tb_top
   import txcps_pkg::*;
;
   typedef struct packed {
      logic [4:0] mult;
      logic half;
      logic inval;
      logic [7:0] src;
      logic [4:0] char_tog;
      logic [4:0] rx_tog;
      logic saw;
      logic chk;
   } txcps_exp_t;

   // ==========
   // Signals
   // ==========
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic tx_pll_rate_select = 1'b0;
   logic [1:0] tx_input_clock_select = 2'h0;
   logic rx_clock_source_select = 1'b0;
   logic align_go = 1'b0;
   logic [3:0] low_len = 4'h2;
   logic [3:0] lane_clk;
   logic tx_phase_align_reset_n;
   logic [4:0] tx_bit_rate_mult_q;
   logic tx_character_clock_out_p, tx_character_clock_out_n;
   logic rx_interface_clock_pair_a_p, rx_interface_clock_pair_a_n;
   logic rx_interface_clock_pair_c_p, rx_interface_clock_pair_c_n;
   logic rx_clock_half_rate_q, mode_invalid_q, align_active_q;
   logic [LANES-1:0][1:0] lane_clock_source_q;
   logic [LANES-1:0][PHASE_W-1:0] lane_phase_q;
   logic [LANES-1:0] lane_locked_q;
   logic saw_align = 1'b0;
   logic cur_r, cur_x;
   logic [1:0] cur_s;
   int num_errors = 0;
   int n_tests = 0;
   txcps_exp_t exp_q[$];
   event sample_ev, mon_done;

   always #25 mclk = ~mclk;

   txcps_top uut (
      .mclk, .resetn, .tx_pll_rate_select, .tx_input_clock_select,
      .rx_clock_source_select, .tx_phase_align_reset_n,
      .tx_lane_a_input_clock(lane_clk[0]), .tx_lane_b_input_clock(lane_clk[1]),
      .tx_lane_c_input_clock(lane_clk[2]), .tx_lane_d_input_clock(lane_clk[3]),
      .tx_bit_rate_mult_q, .tx_character_clock_out_p, .tx_character_clock_out_n,
      .rx_interface_clock_pair_a_p, .rx_interface_clock_pair_a_n,
      .rx_interface_clock_pair_c_p, .rx_interface_clock_pair_c_n,
      .rx_clock_half_rate_q, .lane_clock_source_q, .lane_phase_q,
      .lane_locked_q, .mode_invalid_q, .align_active_q
   );

   txcps_host_model u_host (
      .mclk, .align_go, .low_len, .lane_clk, .tx_phase_align_reset_n
   );

   // ==========
   // Tasks
   // ==========
   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      n_tests++;
      if (seen !== want) begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check

   task automatic print_verdict();
      if (num_errors == 0 && n_tests > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : print_verdict

   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #2;
   endtask : step

   task automatic align(input logic [3:0] len);
      int k;
      saw_align = 1'b0;
      low_len = len;
      align_go = 1'b1;
      step(1);
      align_go = 1'b0;
      step(len + 6);
      for (k = 0; k < 40 && lane_locked_q !== 4'hf; k++) step(1);
      step(2);
   endtask : align

   // Expectations come from the configuration last taken in by a phase reset
   task automatic sample(input logic chk);
      txcps_exp_t e;
      logic [1:0] code;
      code = (cur_s == SEL_LOW) ? SRC_REFERENCE : (cur_s == SEL_HIGH) ? SRC_LANE_A : SRC_OWN_LANE;
      e.mult = cur_r ? MULT_HIGH_RATE : MULT_LOW_RATE;
      e.half = cur_r & ~cur_x;
      e.inval = cur_r & (cur_s != SEL_LOW);
      e.src = {LANES{code}};
      e.char_tog = cur_r ? 5'h10 : 5'h08;
      e.rx_tog = cur_x ? 5'h00 : 5'h08;
      e.saw = cur_r | (cur_s != SEL_LOW);
      e.chk = chk;
      exp_q.push_back(e);
      -> sample_ev;
      @(mon_done);
      #1;
   endtask : sample

   // Second reset runs with the new config already held, so bypass is judged cleanly
   task automatic apply(input logic r, input logic [1:0] s, input logic x, input logic [3:0] len);
      tx_pll_rate_select = r;
      tx_input_clock_select = s;
      rx_clock_source_select = x;
      {cur_r, cur_s, cur_x} = {r, s, x};
      step(4);
      align(len);
      align(len);
      sample(1'b1);
   endtask : apply

   // ==========
   // Output monitor
   // ==========
   // Read mid-cycle, away from the edge that launches the flag
   always @(negedge mclk) if (align_active_q === 1'b1) saw_align = 1'b1;

   initial begin : monitor
      txcps_exp_t e;
      logic [LANES-1:0][PHASE_W-1:0] ph0;
      logic [4:0] nc, nr;
      logic pc, pr;
      forever begin
         @(sample_ev);
         e = exp_q.pop_front();
         ph0 = lane_phase_q;
         {nc, nr, pc, pr} = {10'h000, tx_character_clock_out_p, rx_interface_clock_pair_a_p};
         repeat (16) begin
            @(posedge mclk);
            #1;
            if (tx_character_clock_out_p !== pc) nc++;
            if (rx_interface_clock_pair_a_p !== pr) nr++;
            {pc, pr} = {tx_character_clock_out_p, rx_interface_clock_pair_a_p};
         end
         check(tx_bit_rate_mult_q, e.mult);
         check(rx_clock_half_rate_q, e.half);
         check(mode_invalid_q, e.inval);
         check(lane_clock_source_q, e.src);
         check(lane_locked_q, 4'hf);
         check(lane_phase_q, ph0);
         check(nc, e.char_tog);
         check(nr, e.rx_tog);
         if (e.chk) check(saw_align, e.saw);
         -> mon_done;
      end
   end

   // ==========
   // Main sequence and watchdog
   // ==========
   initial begin : main
      int i;
      void'($urandom(9));
      repeat (5) @(posedge mclk);
      #2;
      resetn = 1'b1;
      step(4);
      for (i = 0; i < 16; i++) apply(i[3], i[2:1], i[0], 4'($urandom_range(5, 2)));
      for (i = 0; i < 4; i++) apply(1'($urandom), 2'($urandom), 1'($urandom), 4'h2);
      // Rate flip with a one-edge reset pulse must leave the old rate in force
      tx_pll_rate_select = ~cur_r;
      step(6);
      align(4'h1);
      sample(1'b0);
      apply(~cur_r, cur_s, cur_x, 4'h2);
      print_verdict();
   end

   // Some 22 configs at under 150 cycles each
   initial begin : watchdog
      #(50 * 6000);
      num_errors++;
      print_verdict();
   end
endmodule : tb_top
